// File: inc/lpw_pkg.sv
package lpw_pkg;
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_BRK = 16'hFFFC;
  localparam logic [15:0] VEC_PIN = 16'hFFFA;
  localparam logic [15:0] VEC_PLL = 16'hFFF8;
  localparam logic [15:0] VEC_T1_CH0 = 16'hFFF6;
  localparam logic [15:0] VEC_T1_CH1 = 16'hFFF4;
  localparam logic [15:0] VEC_T1_OVF = 16'hFFF2;
  localparam logic [15:0] VEC_T2_CH0 = 16'hFFF0;
  localparam logic [15:0] VEC_T2_CH1 = 16'hFFEE;
  localparam logic [15:0] VEC_T2_OVF = 16'hFFEC;
  localparam logic [15:0] VEC_SSI_RX = 16'hFFEA;
  localparam logic [15:0] VEC_SSI_TX = 16'hFFE8;
  localparam logic [15:0] VEC_ASI_ERR = 16'hFFE6;
  localparam logic [15:0] VEC_ASI_RX = 16'hFFE4;
  localparam logic [15:0] VEC_ASI_TX = 16'hFFE2;
  localparam logic [15:0] VEC_KEY = 16'hFFE0;
  localparam logic [15:0] VEC_ADC = 16'hFFDE;
  localparam logic [15:0] VEC_TB = 16'hFFDC;
  localparam int REC_W = 12;
  localparam int REC_LONG = 4096;
  localparam int REC_SHORT = 32;
  // source bit positions
  localparam int TIM_OVF = 0;
  localparam int TIM_CH1 = 1;
  localparam int TIM_CH0 = 2;
  localparam int SSI_TX = 0;
  localparam int SSI_RX = 1;
  localparam int ASI_TX = 0;
  localparam int ASI_RX = 1;
  localparam int ASI_ERR = 2;
  // apb map
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_CFG = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  localparam logic [11:0] ADDR_VEC = 12'h008;
  localparam int CFG_W = 6;
  localparam int CFG_PIN_MASK = 0;
  localparam int CFG_KEY_MASK = 1;
  localparam int CFG_OSC_STOP = 2;
  localparam int CFG_SHORT_REC = 3;
  localparam int CFG_SMON_EN = 4;
  localparam int CFG_SMON_RST = 5;
  localparam logic [5:0] CFG_RESET = 6'h03;
  typedef enum logic [1:0] {LPW_RUN, LPW_WAIT, LPW_STOP, LPW_RECOVER} lpw_state_e;
endpackage : lpw_pkg

// File: verilog/lpw_wake.sv
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module lpw_wake #(
  parameter int REC_LONG_CYC = lpw_pkg::REC_LONG,
  parameter int REC_SHORT_CYC = lpw_pkg::REC_SHORT
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [lpw_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_wait_req,
  input wire logic i_stop_req,
  input wire logic i_ext_rst_n,
  input wire logic i_irq_pin,
  input wire logic i_brk_req,
  input wire logic i_wdog_expire,
  input wire logic i_supply_low,
  input wire logic i_pll_req,
  input wire logic i_key_req,
  input wire logic [2:0] i_timer_one_req,
  input wire logic [2:0] i_timer_two_req,
  input wire logic [1:0] i_ssi_req,
  input wire logic [2:0] i_asi_req,
  input wire logic i_adc_req,
  input wire logic i_tb_req,
  output logic [1:0] o_mode,
  output logic o_cpu_clk_en,
  output logic o_sys_clk_en,
  output logic o_osc_en,
  output logic o_pll_en,
  output logic o_cg_out_en,
  output logic o_asi_run,
  output logic o_ssi_run,
  output logic o_ssi_abort,
  output logic o_tim_run,
  output logic o_tb_run,
  output logic o_tb_access_ok,
  output logic o_supply_mon_run,
  output logic o_part_reset,
  output logic o_vec_valid,
  output logic [15:0] o_vector
);
  import lpw_pkg::*;

  localparam logic [REC_W-1:0] LONG_LOAD = REC_W'(REC_LONG_CYC - 1);
  localparam logic [REC_W-1:0] SHORT_LOAD = REC_W'(REC_SHORT_CYC - 1);

  logic rst_s1_reg;
  logic rst_n;
  logic ext_s1_reg;
  logic ext_s2_reg;
  logic pin_s1_reg;
  logic pin_s2_reg;
  logic pin_s3_reg;
  logic pin_fall;
  lpw_state_e state_reg;
  lpw_state_e state_next;
  logic [REC_W-1:0] cnt_reg;
  logic [CFG_W-1:0] cfg_reg;
  logic [31:0] prdata_reg;
  logic [15:0] vec_reg;
  logic pend_rst_reg;
  logic vld_reg;
  logic prst_reg;
  logic abort_reg;
  logic wake;
  logic wake_rst;
  logic [15:0] wake_vec;
  logic smon_trip;
  logic in_stop;
  logic wr_en;
  logic rd_setup;

  // reset release through two flops
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  // pins are asynchronous to the crystal clock
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1_reg <= 1'b1;
      ext_s2_reg <= 1'b1;
      pin_s1_reg <= 1'b1;
      pin_s2_reg <= 1'b1;
      pin_s3_reg <= 1'b1;
    end else begin
      ext_s1_reg <= i_ext_rst_n;
      ext_s2_reg <= ext_s1_reg;
      pin_s1_reg <= i_irq_pin;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  // edge detector stays on in both modes
  assign pin_fall = pin_s3_reg & ~pin_s2_reg;

  // apb slave, zero wait states
  assign wr_en = i_psel & i_penable & i_pwrite;
  assign rd_setup = i_psel & ~i_penable & ~i_pwrite;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & (i_paddr != ADDR_CFG) & (i_paddr != ADDR_STAT)
                     & (i_paddr != ADDR_VEC);
  assign o_prdata = prdata_reg;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= CFG_RESET;
    end else if (wr_en && i_paddr == ADDR_CFG) begin
      cfg_reg <= i_pwdata[CFG_W-1:0];
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= 32'h0;
    end else if (rd_setup) begin
      if (i_paddr == ADDR_CFG) begin
        prdata_reg <= {{(32-CFG_W){1'b0}}, cfg_reg};
      end else if (i_paddr == ADDR_STAT) begin
        prdata_reg <= {{(30-REC_W){1'b0}}, cnt_reg, state_reg};
      end else if (i_paddr == ADDR_VEC) begin
        prdata_reg <= {16'h0, vec_reg};
      end else begin
        prdata_reg <= 32'h0;
      end
    end
  end

  assign in_stop = (state_reg == LPW_STOP);
  assign smon_trip = cfg_reg[CFG_SMON_EN] & cfg_reg[CFG_SMON_RST] & i_supply_low;

  // wake selection; resets first, then vectors by descending address
  always_comb begin
    wake = 1'b1;
    wake_rst = 1'b0;
    wake_vec = VEC_RESET;
    if (state_reg != LPW_WAIT && state_reg != LPW_STOP) begin
      wake = 1'b0;
    end else if (!ext_s2_reg) begin
      wake_rst = 1'b1;
    end else if (smon_trip) begin
      wake_rst = 1'b1;
    end else if (!in_stop && i_wdog_expire) begin
      wake_rst = 1'b1;
    end else if (i_brk_req) begin
      wake_vec = VEC_BRK;
    end else if (pin_fall && !cfg_reg[CFG_PIN_MASK]) begin
      wake_vec = VEC_PIN;
    end else if (!in_stop && i_pll_req) begin
      wake_vec = VEC_PLL;
    end else if (!in_stop && i_timer_one_req[TIM_CH0]) begin
      wake_vec = VEC_T1_CH0;
    end else if (!in_stop && i_timer_one_req[TIM_CH1]) begin
      wake_vec = VEC_T1_CH1;
    end else if (!in_stop && i_timer_one_req[TIM_OVF]) begin
      wake_vec = VEC_T1_OVF;
    end else if (!in_stop && i_timer_two_req[TIM_CH0]) begin
      wake_vec = VEC_T2_CH0;
    end else if (!in_stop && i_timer_two_req[TIM_CH1]) begin
      wake_vec = VEC_T2_CH1;
    end else if (!in_stop && i_timer_two_req[TIM_OVF]) begin
      wake_vec = VEC_T2_OVF;
    end else if (!in_stop && i_ssi_req[SSI_RX]) begin
      wake_vec = VEC_SSI_RX;
    end else if (!in_stop && i_ssi_req[SSI_TX]) begin
      wake_vec = VEC_SSI_TX;
    end else if (!in_stop && i_asi_req[ASI_ERR]) begin
      wake_vec = VEC_ASI_ERR;
    end else if (!in_stop && i_asi_req[ASI_RX]) begin
      wake_vec = VEC_ASI_RX;
    end else if (!in_stop && i_asi_req[ASI_TX]) begin
      wake_vec = VEC_ASI_TX;
    end else if (i_key_req && !cfg_reg[CFG_KEY_MASK]) begin
      wake_vec = VEC_KEY;
    end else if (!in_stop && i_adc_req) begin
      wake_vec = VEC_ADC;
    end else if (i_tb_req && (!in_stop || cfg_reg[CFG_OSC_STOP])) begin
      wake_vec = VEC_TB;
    end else begin
      wake = 1'b0;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      LPW_RUN: begin
        if (i_stop_req) begin
          state_next = LPW_STOP;
        end else if (i_wait_req) begin
          state_next = LPW_WAIT;
        end
      end
      LPW_WAIT: begin
        if (wake) begin
          state_next = LPW_RUN;
        end
      end
      LPW_STOP: begin
        if (wake) begin
          state_next = LPW_RECOVER;
        end
      end
      LPW_RECOVER: begin
        if (cnt_reg == '0) begin
          state_next = LPW_RUN;
        end
      end
      default: begin
        state_next = LPW_RUN;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= LPW_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // recovery counter on the crystal clock; long hold suits a crystal
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else if (in_stop && wake) begin
      cnt_reg <= cfg_reg[CFG_SHORT_REC] ? SHORT_LOAD : LONG_LOAD;
    end else if (state_reg == LPW_RECOVER && cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // vector held from the wake until the fetch is released
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      vec_reg <= VEC_RESET;
      pend_rst_reg <= 1'b0;
    end else if (wake) begin
      vec_reg <= wake_vec;
      pend_rst_reg <= wake_rst;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      vld_reg <= 1'b0;
      prst_reg <= 1'b0;
    end else if (state_reg == LPW_WAIT) begin
      vld_reg <= wake;
      prst_reg <= wake & wake_rst;
    end else if (state_reg == LPW_RECOVER) begin
      vld_reg <= (cnt_reg == '0);
      prst_reg <= (cnt_reg == '0) & pend_rst_reg;
    end else begin
      vld_reg <= 1'b0;
      prst_reg <= 1'b0;
    end
  end

  // reset exit from stop kills any sync serial transfer in flight
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      abort_reg <= 1'b0;
    end else begin
      abort_reg <= in_stop & wake & wake_rst;
    end
  end

  assign o_vector = vec_reg;
  assign o_vec_valid = vld_reg;
  assign o_part_reset = prst_reg;
  assign o_ssi_abort = abort_reg;
  assign o_mode = state_reg;
  assign o_cpu_clk_en = (state_reg == LPW_RUN);
  assign o_sys_clk_en = (state_reg == LPW_RUN) | (state_reg == LPW_WAIT);
  assign o_asi_run = o_sys_clk_en;
  assign o_ssi_run = o_sys_clk_en;
  assign o_tim_run = o_sys_clk_en;
  assign o_tb_run = o_sys_clk_en | cfg_reg[CFG_OSC_STOP];
  assign o_tb_access_ok = (state_reg == LPW_RUN);
  assign o_supply_mon_run = cfg_reg[CFG_SMON_EN];
  assign o_pll_en = ~in_stop;
  assign o_osc_en = ~in_stop | cfg_reg[CFG_OSC_STOP];
  assign o_cg_out_en = ~in_stop | cfg_reg[CFG_OSC_STOP];

  // cycles spent in recovery, checked against the selected hold
  logic [REC_W:0] rec_len_reg;
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rec_len_reg <= '0;
    end else if (state_reg == LPW_RECOVER) begin
      rec_len_reg <= rec_len_reg + 1'b1;
    end else begin
      rec_len_reg <= '0;
    end
  end

  sequence s_stop_wake_rst;
    in_stop && wake && wake_rst;
  endsequence
  sequence s_recover_done;
    state_reg == LPW_RECOVER && cnt_reg == '0;
  endsequence

  a_pin_wakes_wait: assert property (@(posedge i_clk) disable iff (!rst_n)
    state_reg == LPW_WAIT && pin_fall && !cfg_reg[CFG_PIN_MASK] |=> state_reg == LPW_RUN)
    else $error("unmasked pin edge did not end wait");
  a_key_wakes_stop: assert property (@(posedge i_clk) disable iff (!rst_n)
    in_stop && i_key_req && !cfg_reg[CFG_KEY_MASK] |=> state_reg == LPW_RECOVER)
    else $error("unmasked keypad request did not end stop");
  a_smon_reset: assert property (@(posedge i_clk) disable iff (!rst_n)
    state_reg == LPW_WAIT && smon_trip |=> o_part_reset && o_vector == VEC_RESET)
    else $error("supply monitor reset did not end wait");
  a_stop_halts: assert property (@(posedge i_clk) disable iff (!rst_n)
    in_stop |-> !o_asi_run && !o_tim_run && !o_ssi_run && !o_cpu_clk_en)
    else $error("peripheral clock running in stop");
  a_wait_runs: assert property (@(posedge i_clk) disable iff (!rst_n)
    state_reg == LPW_WAIT |-> o_asi_run && o_tb_run && !o_tb_access_ok)
    else $error("wait mode peripheral state wrong");
  a_tb_in_stop: assert property (@(posedge i_clk) disable iff (!rst_n)
    in_stop |-> o_tb_run == cfg_reg[CFG_OSC_STOP])
    else $error("timebase run state wrong in stop");
  a_ssi_abort: assert property (@(posedge i_clk) disable iff (!rst_n)
    s_stop_wake_rst |=> o_ssi_abort ##1 !o_ssi_abort)
    else $error("sync serial abort not a single pulse");
  a_wdog_vector: assert property (@(posedge i_clk) disable iff (!rst_n)
    state_reg == LPW_WAIT && i_wdog_expire && ext_s2_reg && !smon_trip
    |=> o_part_reset && o_vec_valid && o_vector == VEC_RESET)
    else $error("watchdog expiry in wait did not reset");
  a_rec_hold: assert property (@(posedge i_clk) disable iff (!rst_n)
    s_recover_done |-> rec_len_reg == (cfg_reg[CFG_SHORT_REC]
      ? (REC_W+1)'(REC_SHORT_CYC - 1) : (REC_W+1)'(REC_LONG_CYC - 1)))
    else $error("stop recovery length wrong");
  a_rec_release: assert property (@(posedge i_clk) disable iff (!rst_n)
    s_recover_done |=> o_vec_valid && o_sys_clk_en)
    else $error("vector not released at terminal count");
  a_osc_off: assert property (@(posedge i_clk) disable iff (!rst_n)
    in_stop && !cfg_reg[CFG_OSC_STOP] |-> !o_osc_en && !o_pll_en && !o_cg_out_en)
    else $error("clock generator not shut down in stop");
  a_brk_vector: assert property (@(posedge i_clk) disable iff (!rst_n)
    state_reg == LPW_WAIT && i_brk_req && ext_s2_reg && !smon_trip && !i_wdog_expire
    |=> o_vec_valid && o_vector == VEC_BRK)
    else $error("break did not load its vector");

endmodule : lpw_wake

// File: tb/lpw_core_model.sv
`timescale 1ns/1ps
module lpw_core_model (
  input wire logic i_clk,
  output logic o_wait_req,
  output logic o_stop_req,
  output logic o_ext_rst_n,
  output logic o_irq_pin,
  output logic [17:0] o_src
);
  initial begin
    o_wait_req = 1'b0;
    o_stop_req = 1'b0;
    o_ext_rst_n = 1'b1;
    o_irq_pin = 1'b1;
    o_src = 18'h0;
  end
  // one-cycle instruction pulse; wait and stop are never raised together
  task automatic go(input logic stop);
    @(posedge i_clk);
    o_wait_req <= ~stop;
    o_stop_req <= stop;
    @(posedge i_clk);
    o_wait_req <= 1'b0;
    o_stop_req <= 1'b0;
  endtask : go
  // wake sources are levels, held until the bench drops them
  task automatic drive(input logic [17:0] src, input logic pin, input logic rst_n);
    @(posedge i_clk);
    o_src <= src;
    o_irq_pin <= pin;
    o_ext_rst_n <= rst_n;
  endtask : drive
endmodule : lpw_core_model

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import lpw_pkg::*;
  localparam int LONG = 64;
  localparam int SHORT = 32;
  localparam int LIMIT = 20000;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0;
  logic [31:0] o_prdata;
  logic [15:0] o_vector;
  logic [1:0] o_mode;
  logic o_pready, o_pslverr, o_cpu_clk_en, o_sys_clk_en, o_osc_en, o_pll_en, o_cg_out_en;
  logic o_asi_run, o_ssi_run, o_ssi_abort, o_tim_run, o_tb_run, o_tb_access_ok;
  logic o_supply_mon_run, o_part_reset, o_vec_valid, wait_req, stop_req, ext_rst_n, irq_pin;
  logic [17:0] src;
  logic [31:0] rd;
  logic err;
  int aborts = 0;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  int n3;
  logic [15:0] vtab [18] = '{VEC_BRK, VEC_PLL, VEC_T1_OVF, VEC_T1_CH1, VEC_T1_CH0, VEC_T2_OVF,
    VEC_T2_CH1, VEC_T2_CH0, VEC_SSI_TX, VEC_SSI_RX, VEC_ASI_TX, VEC_ASI_RX, VEC_ASI_ERR,
    VEC_KEY, VEC_ADC, VEC_TB, VEC_RESET, VEC_RESET};

  always #5 i_clk = ~i_clk;

  lpw_core_model lpw_core_model_inst (.i_clk(i_clk), .o_wait_req(wait_req),
    .o_stop_req(stop_req), .o_ext_rst_n(ext_rst_n), .o_irq_pin(irq_pin), .o_src(src));

  lpw_wake #(.REC_LONG_CYC(LONG), .REC_SHORT_CYC(SHORT)) lpw_wake_inst (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_wait_req(wait_req),
    .i_stop_req(stop_req), .i_ext_rst_n(ext_rst_n), .i_irq_pin(irq_pin),
    .i_brk_req(src[0]), .i_wdog_expire(src[16]), .i_supply_low(src[17]),
    .i_pll_req(src[1]), .i_key_req(src[13]), .i_timer_one_req(src[4:2]), .i_timer_two_req(src[7:5]),
    .i_ssi_req(src[9:8]), .i_asi_req(src[12:10]), .i_adc_req(src[14]), .i_tb_req(src[15]),
    .o_mode(o_mode), .o_cpu_clk_en(o_cpu_clk_en), .o_sys_clk_en(o_sys_clk_en),
    .o_osc_en(o_osc_en), .o_pll_en(o_pll_en), .o_cg_out_en(o_cg_out_en),
    .o_asi_run(o_asi_run), .o_ssi_run(o_ssi_run), .o_ssi_abort(o_ssi_abort),
    .o_tim_run(o_tim_run), .o_tb_run(o_tb_run), .o_tb_access_ok(o_tb_access_ok),
    .o_supply_mon_run(o_supply_mon_run), .o_part_reset(o_part_reset),
    .o_vec_valid(o_vec_valid), .o_vector(o_vector));

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    @(posedge i_clk);
    // no private limit here: only the bench timeout may end a stalled access
    while (o_pready !== 1'b1) begin
      @(posedge i_clk);
    end
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  // counts recovery cycles so the hold length is measured, not assumed
  task automatic wake();
    n3 = 0;
    for (int n = 0; n < 300; n++) begin
      @(posedge i_clk);
      #1;
      if (o_vec_valid === 1'b1) return;
      if (o_mode === 2'h3) n3++;
    end
    chk("wake pulse", 32'h1, 32'h0);
  endtask : wake

  task automatic enter(input logic stop, input logic [5:0] cfg);
    apb(1'b1, ADDR_CFG, 32'(cfg));
    lpw_core_model_inst.go(stop);
    @(posedge i_clk);
    #1;
  endtask : enter

  always @(posedge i_clk) begin
    cycles++;
    if (o_ssi_abort === 1'b1) aborts++;
    if (cycles == LIMIT) begin
      errors++;
      give_verdict();
    end
  end

  initial begin
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    apb(1'b0, ADDR_CFG, 32'h0);
    chk("cfg reset", 32'h3, rd);
    apb(1'b1, ADDR_VEC, 32'h0);
    apb(1'b0, ADDR_VEC, 32'h0);
    chk("vector read-only", 32'(VEC_RESET), rd);
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped error", 32'h1, 32'(err));
    chk("unmapped data", 32'h0, rd);
    for (int i = 0; i < 18; i++) begin
      enter(1'b0, 6'h30);
      chk("wait mode", 32'h1, 32'(o_mode));
      chk("wait enables", 32'h0D, 32'({o_cpu_clk_en, o_sys_clk_en, o_asi_run,
        o_tb_access_ok, o_supply_mon_run}));
      lpw_core_model_inst.drive(18'h1 << i, 1'b1, 1'b1);
      wake();
      chk("wait vector", 32'(vtab[i]), 32'(o_vector));
      chk("wait part reset", 32'(i >= 16), 32'(o_part_reset));
      lpw_core_model_inst.drive(18'h0, 1'b1, 1'b1);
    end
    enter(1'b0, 6'h30);
    lpw_core_model_inst.drive(18'h0, 1'b0, 1'b1);
    wake();
    chk("pin vector", 32'(VEC_PIN), 32'(o_vector));
    lpw_core_model_inst.drive(18'h0, 1'b1, 1'b1);
    enter(1'b0, 6'h30);
    lpw_core_model_inst.drive(18'h0, 1'b1, 1'b0);
    wake();
    chk("reset pin vector", 32'(VEC_RESET), 32'(o_vector));
    chk("reset pin part reset", 32'h1, 32'(o_part_reset));
    lpw_core_model_inst.drive(18'h0, 1'b1, 1'b1);
    // long recovery; a wait-only source must not end stop
    enter(1'b1, 6'h30);
    chk("stop mode", 32'h2, 32'(o_mode));
    chk("stop enables", 32'h0, 32'({o_cpu_clk_en, o_sys_clk_en, o_asi_run, o_ssi_run,
      o_tim_run, o_tb_run, o_osc_en, o_pll_en, o_cg_out_en}));
    lpw_core_model_inst.drive(18'h2, 1'b1, 1'b1);
    repeat (20) @(posedge i_clk);
    #1;
    chk("pll in stop", 32'h2, 32'(o_mode));
    lpw_core_model_inst.drive(18'h1 << 13, 1'b1, 1'b1);
    wake();
    chk("long recovery", 32'(LONG), 32'(n3));
    chk("key vector", 32'(VEC_KEY), 32'(o_vector));
    chk("run after stop", 32'h7, 32'({o_cpu_clk_en, o_tim_run, o_asi_run}));
    lpw_core_model_inst.drive(18'h0, 1'b1, 1'b1);
    repeat (3) @(posedge i_clk);
    chk("no abort", 32'h0, 32'(aborts));
    enter(1'b1, 6'h3C);
    chk("osc stop enables", 32'hD, 32'({o_osc_en, o_cg_out_en, o_pll_en, o_tb_run}));
    lpw_core_model_inst.drive(18'h1 << 15, 1'b1, 1'b1);
    wake();
    chk("short recovery", 32'(SHORT), 32'(n3));
    chk("timebase vector", 32'(VEC_TB), 32'(o_vector));
    lpw_core_model_inst.drive(18'h0, 1'b1, 1'b1);
    enter(1'b1, 6'h30);
    lpw_core_model_inst.drive(18'h1, 1'b1, 1'b1);
    wake();
    chk("break vector", 32'(VEC_BRK), 32'(o_vector));
    lpw_core_model_inst.drive(18'h0, 1'b1, 1'b1);
    // masked pin and keypad, and timebase without the oscillator, are ignored in stop
    enter(1'b1, 6'h33);
    lpw_core_model_inst.drive(18'hA000, 1'b0, 1'b1);
    repeat (20) @(posedge i_clk);
    #1;
    chk("masked in stop", 32'h2, 32'(o_mode));
    lpw_core_model_inst.drive(18'h0, 1'b1, 1'b0);
    wake();
    chk("stop reset vector", 32'(VEC_RESET), 32'(o_vector));
    chk("stop reset recovery", 32'(LONG), 32'(n3));
    chk("stop reset part reset", 32'h1, 32'(o_part_reset));
    lpw_core_model_inst.drive(18'h0, 1'b1, 1'b1);
    repeat (3) @(posedge i_clk);
    chk("sync serial abort", 32'h1, 32'(aborts));
    give_verdict();
  end
endmodule : tb_top
